// [core/eep_consts.svh]
// Functional notes
// - 512 bytes, sixteen-byte pages
// - partial page writes keep other bytes
// - self-timed write, at most 4 ms
// - protect pin high blocks all writes; here wp_unlock high still lets them through
// - protect pin low or open writes
// - unlock input overrides protect pin
// - two chip-select pins in address
// - open chip-select pins read zero
// - ignore bus until power-on reset releases
// - supply loss returns standby, no write
// - stop enters standby after write done
// - lockable sixteen-byte identification page
// - data line open-drain, never driven high
// - sample and shift with serial clock
// - work with serial clock up to 1 MHz
// - address byte 1010, selects, block, direction
// - page write wraps low four bits
// - no acknowledge while write runs
// - start and stop seen with clock high
`ifndef EEP_CONSTS_SVH
`define EEP_CONSTS_SVH

// ==========================================
// array geometry
`define EEP_MEM_BYTES 512
`define EEP_PAGE_BYTES 16
`define EEP_ERASED 8'hff

// ==========================================
// device address byte layout
`define EEP_CODE_MAIN 4'ha
`define EEP_CODE_ID 4'hb
`define EEP_CODE_MSB 7
`define EEP_CODE_LSB 4
`define EEP_CSH_BIT 3
`define EEP_CSL_BIT 2
`define EEP_BLK_BIT 1
`define EEP_RW_BIT 0

// ==========================================
// timing
`define EEP_T_WR_NS 4000000
`define EEP_CLK_PERIOD_NS 100

`endif

// [core/eep_pkg.sv]
`include "eep_consts.svh"

package eep_pkg;

  // ==========================================
  // pins and protocol state
  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
    logic chip_select_bit_high;
    logic chip_select_bit_low;
  } eep_pin_in_s;

  typedef struct packed {
    logic o;
    logic oe;
  } eep_sda_out_s;

  typedef enum logic [2:0] {
    EEP_IDLE,
    EEP_DEV,
    EEP_ADDR,
    EEP_WDATA,
    EEP_ACK,
    EEP_RD,
    EEP_RACK
  } eep_state_e;

  typedef logic [7:0] eep_byte_t;

  typedef struct packed {
    eep_state_e state;
    eep_state_e after_ack;
    logic [3:0] cnt;
    eep_byte_t sr;
    logic [8:0] ptr;
    logic blk;
    logic is_id;
    logic rd_ack;
    logic scl_q;
    logic sda_q;
    logic busy;
    logic [31:0] timer;
    logic wr_id;
    logic [4:0] wr_page;
    logic [`EEP_PAGE_BYTES-1:0] mask;
    eep_byte_t [`EEP_PAGE_BYTES-1:0] pbuf;
    eep_byte_t [`EEP_MEM_BYTES-1:0] mem;
    eep_byte_t [`EEP_PAGE_BYTES-1:0] idp;
    logic id_locked;
    logic standby;
    eep_sda_out_s sda;
  } eep_core_s;

endpackage : eep_pkg

// [core/eep_sync.sv]
`timescale 1ns/100ps

module eep_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // stage 0 is read only by stage 1
  logic [1:0][W-1:0] r;
  logic [1:0][W-1:0] next_r;

  always_comb begin
    next_r = {r[0], d};
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign q = r[1];

endmodule : eep_sync

// [core/eep_slave.sv]
`timescale 1ns/100ps
`include "eep_consts.svh"

module eep_slave #(
  parameter int unsigned WRITE_CYCLES = `EEP_T_WR_NS / `EEP_CLK_PERIOD_NS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire eep_pkg::eep_pin_in_s pins,
  input wire logic wp_unlock,
  input wire logic id_lock_req,
  output eep_pkg::eep_sda_out_s sda,
  output logic busy,
  output logic standby,
  output logic id_locked
);
  import eep_pkg::*;

  eep_core_s r;
  eep_core_s next_r;
  eep_pin_in_s ps;

  // ==========================================
  // pin synchronisers
  // open chip-select pins rely on pad pull-downs to read zero
  eep_sync #(
    .W($bits(eep_pin_in_s))
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .d(pins),
    .q(ps)
  );

  // ==========================================
  // bus events
  // 10 MHz sampling gives five samples per high phase at 1 MHz
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic wr_allowed;
  logic dev_match;
  eep_byte_t rd_byte;

  always_comb begin
    scl_rise = ps.scl & ~r.scl_q;
    scl_fall = ~ps.scl & r.scl_q;
    start_seen = ps.scl & r.scl_q & r.sda_q & ~ps.sda;
    stop_seen = ps.scl & r.scl_q & ~r.sda_q & ps.sda;
    // floating protect pin is pulled low at the pad
    wr_allowed = ~ps.wp | wp_unlock;
    dev_match = (r.sr[`EEP_CODE_MSB:`EEP_CODE_LSB] == `EEP_CODE_MAIN ||
                 r.sr[`EEP_CODE_MSB:`EEP_CODE_LSB] == `EEP_CODE_ID) &&
                r.sr[`EEP_CSH_BIT] == ps.chip_select_bit_high &&
                r.sr[`EEP_CSL_BIT] == ps.chip_select_bit_low;
    rd_byte = r.is_id ? r.idp[r.ptr[3:0]] : r.mem[r.ptr];
  end

  // ==========================================
  // protocol engine
  always_comb begin
    next_r = r;
    next_r.scl_q = ps.scl;
    next_r.sda_q = ps.sda;
    next_r.sda.o = 1'b0; // low or released only
    if (id_lock_req) begin
      next_r.id_locked = 1'b1;
    end

    // self-timed programming cycle, no serial clock needed
    if (r.busy) begin
      if (r.timer <= 32'h1) begin
        next_r.busy = 1'b0;
        next_r.timer = '0;
        for (int i = 0; i < `EEP_PAGE_BYTES; i++) begin
          if (r.mask[i]) begin
            // only received bytes change
            if (r.wr_id) begin
              next_r.idp[i] = r.pbuf[i];
            end else begin
              next_r.mem[{r.wr_page, i[3:0]}] = r.pbuf[i];
            end
          end
        end
        next_r.mask = '0;
      end else begin
        next_r.timer = r.timer - 32'h1;
      end
    end

    if (start_seen) begin
      next_r.state = EEP_DEV;
      next_r.cnt = '0;
      next_r.sda.oe = 1'b0;
      // a restart abandons unwritten data
      if (!r.busy) begin
        next_r.mask = '0;
      end
    end else if (stop_seen) begin
      next_r.state = EEP_IDLE;
      next_r.sda.oe = 1'b0;
      if (!r.busy && r.mask != '0) begin
        // protected writes are dropped silently
        if (wr_allowed && !(r.wr_id && r.id_locked)) begin
          next_r.busy = 1'b1;
          next_r.timer = WRITE_CYCLES;
        end else begin
          next_r.mask = '0;
        end
      end
    end else begin
      case (r.state)
        EEP_IDLE: begin
          next_r.sda.oe = 1'b0; // nothing until a start
        end
        EEP_DEV, EEP_ADDR, EEP_WDATA: begin
          if (scl_rise && r.cnt < 4'h8) begin
            next_r.sr = {r.sr[6:0], ps.sda};
            next_r.cnt = r.cnt + 4'h1;
          end else if (scl_fall && r.cnt == 4'h8) begin
            next_r.cnt = '0;
            next_r.state = EEP_ACK;
            next_r.sda.oe = 1'b1;
            case (r.state)
              EEP_DEV: begin
                // busy device stays silent to allow polling
                if (!dev_match || r.busy) begin
                  next_r.state = EEP_IDLE;
                  next_r.sda.oe = 1'b0;
                end else begin
                  next_r.is_id = (r.sr[`EEP_CODE_MSB:`EEP_CODE_LSB] == `EEP_CODE_ID);
                  next_r.blk = r.sr[`EEP_BLK_BIT];
                  next_r.after_ack = r.sr[`EEP_RW_BIT] ? EEP_RD : EEP_ADDR;
                end
              end
              EEP_ADDR: begin
                next_r.ptr = r.is_id ? {5'h0, r.sr[3:0]} : {r.blk, r.sr};
                next_r.mask = '0;
                next_r.after_ack = EEP_WDATA;
              end
              default: begin
                // acknowledge even when protected
                next_r.pbuf[r.ptr[3:0]] = r.sr;
                next_r.mask[r.ptr[3:0]] = 1'b1;
                next_r.wr_page = r.ptr[8:4];
                next_r.wr_id = r.is_id;
                next_r.ptr[3:0] = r.ptr[3:0] + 4'h1; // wraps in page
                next_r.after_ack = EEP_WDATA;
              end
            endcase
          end
        end
        EEP_ACK: begin
          if (scl_fall) begin
            next_r.sda.oe = 1'b0;
            next_r.state = r.after_ack;
            next_r.cnt = '0;
            if (r.after_ack == EEP_RD) begin
              next_r.sr = rd_byte;
              next_r.sda.oe = ~rd_byte[7];
              if (r.is_id) begin
                next_r.ptr[3:0] = r.ptr[3:0] + 4'h1;
              end else begin
                next_r.ptr = r.ptr + 9'h1;
              end
            end
          end
        end
        EEP_RD: begin
          if (scl_rise) begin
            next_r.cnt = r.cnt + 4'h1;
          end else if (scl_fall) begin
            if (r.cnt >= 4'h8) begin
              next_r.sda.oe = 1'b0;
              next_r.state = EEP_RACK;
            end else begin
              next_r.sda.oe = ~r.sr[3'h7 - r.cnt[2:0]];
            end
          end
        end
        EEP_RACK: begin
          if (scl_rise) begin
            next_r.rd_ack = ~ps.sda;
          end else if (scl_fall) begin
            if (r.rd_ack) begin
              next_r.state = EEP_RD;
              next_r.cnt = '0;
              next_r.sr = rd_byte;
              next_r.sda.oe = ~rd_byte[7];
              if (r.is_id) begin
                next_r.ptr[3:0] = r.ptr[3:0] + 4'h1;
              end else begin
                next_r.ptr = r.ptr + 9'h1;
              end
            end else begin
              next_r.state = EEP_IDLE;
            end
          end
        end
        default: begin
          next_r.state = EEP_IDLE;
          next_r.sda.oe = 1'b0;
        end
      endcase
    end
    // standby only once idle and programming finished
    next_r.standby = (next_r.state == EEP_IDLE) && !next_r.busy;
  end

  // ==========================================
  // state register
  // power-on reset aborts any write and lands in standby
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r.state <= EEP_IDLE;
      r.after_ack <= EEP_IDLE;
      r.cnt <= '0;
      r.sr <= '0;
      r.ptr <= '0;
      r.blk <= 1'b0;
      r.is_id <= 1'b0;
      r.rd_ack <= 1'b0;
      // match the cleared synchroniser so no false start or stop follows reset
      r.scl_q <= 1'b0;
      r.sda_q <= 1'b0;
      r.busy <= 1'b0;
      r.timer <= '0;
      r.wr_id <= 1'b0;
      r.wr_page <= '0;
      r.mask <= '0;
      r.pbuf <= '0;
      // flops stand in for cells, so contents do not survive reset
      r.mem <= {`EEP_MEM_BYTES{`EEP_ERASED}};
      r.idp <= {`EEP_PAGE_BYTES{`EEP_ERASED}};
      r.id_locked <= 1'b0;
      r.standby <= 1'b1;
      r.sda <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign sda = r.sda;
  assign busy = r.busy;
  assign standby = r.standby;
  assign id_locked = r.id_locked;

endmodule : eep_slave

// [tb/eep_checker.sv]
`timescale 1ns/100ps

module eep_checker #(
  parameter int unsigned WRITE_CYCLES = 40000
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire eep_pkg::eep_pin_in_s pins,
  input wire logic wp_unlock,
  input wire logic id_lock_req,
  input wire eep_pkg::eep_sda_out_s sda,
  input wire logic busy,
  input wire logic standby,
  input wire logic id_locked
);
  import eep_pkg::*;
  // ====
  // write cycle length
  int unsigned bcnt;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) bcnt <= 0;
    else if (busy) bcnt <= bcnt + 1;
    else bcnt <= 0;
  end
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  chk_data_low_only: assert property (sda.o == 1'b0)
    else $error("data pin driven high");
  chk_busy_no_standby: assert property (busy |-> !standby)
    else $error("standby during write");
  chk_id_lock_sticky: assert property (id_locked |=> id_locked)
    else $error("id lock cleared");
  chk_id_lock_set: assert property (id_lock_req |-> ##[1:2] id_locked)
    else $error("id lock not set");
  chk_protect_no_write: assert property ($rose(busy) |-> !$past(pins.wp, 4) || $past(wp_unlock))
    else $error("write under protect");
  chk_write_time: assert property ($fell(busy) |-> bcnt + 2 >= WRITE_CYCLES && bcnt <= WRITE_CYCLES + 2)
    else $error("write cycle length wrong");
  chk_busy_quiet: assert property (busy |-> !sda.oe)
    else $error("data pulled while busy");
  chk_reset_standby: assert property ($fell(rst) |-> standby && !busy && !sda.oe)
    else $error("not standby after reset");
  chk_oe_scl_low: assert property ($changed(sda.oe) |-> !$past(pins.scl, 2))
    else $error("data changed with clock high");
endmodule : eep_checker

// [tb/eep_master.sv]
`timescale 1ns/100ps

module eep_master (
  input wire logic ref_clk,
  input wire logic dev_oe,
  output logic scl,
  output logic m_oe,
  output logic line
);
  // ====
  // open-drain wire, pulled up
  assign line = !(dev_oe | m_oe);
  initial begin
    scl = 1'b1;
    m_oe = 1'b0;
  end
  // half bit of 500 ns keeps under 1 MHz
  task automatic hc;
    repeat (5) @(negedge ref_clk);
  endtask : hc
  task automatic start;
    m_oe = 1'b0;
    hc();
    scl = 1'b1;
    hc();
    m_oe = 1'b1;
    hc();
    scl = 1'b0;
    @(negedge ref_clk);
  endtask : start
  task automatic stop;
    m_oe = 1'b1;
    hc();
    scl = 1'b1;
    hc();
    m_oe = 1'b0;
    hc();
  endtask : stop
  // extra cycle after fall gives data hold
  task automatic bit_io(input logic b, output logic r);
    m_oe = !b;
    hc();
    scl = 1'b1;
    hc();
    r = line;
    scl = 1'b0;
    @(negedge ref_clk);
  endtask : bit_io
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wr
  task automatic rd(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!more, r);
  endtask : rd
endmodule : eep_master

// [tb/eep_slave_tb.sv]
`timescale 1ns/100ps

module eep_slave_tb;
  import eep_pkg::*;
  localparam int WC = 400;
  logic ref_clk, rst, ce, wp, csh, csl, wp_unlock, id_lock_req;
  logic busy, standby, id_locked, scl, m_oe, line;
  eep_pin_in_s pins;
  eep_sda_out_s sda;
  logic [7:0] mdl [512];
  int n_fail, cmp_count;
  assign pins = {scl, line, wp, csh, csl};
  eep_slave #(.WRITE_CYCLES(WC)) i_eep_slave (.ref_clk(ref_clk), .rst(rst), .ce(ce), .pins(pins),
    .wp_unlock(wp_unlock), .id_lock_req(id_lock_req), .sda(sda), .busy(busy), .standby(standby),
    .id_locked(id_locked));
  eep_master i_eep_master (.ref_clk(ref_clk), .dev_oe(sda.oe), .scl(scl), .m_oe(m_oe), .line(line));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ====
  // checking
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  // ====
  // transfers; data byte is the start address plus its index, while the address wraps in the page
  task automatic wtx(input logic [7:0] dev, input logic [7:0] a, input int n, input logic ok);
    logic k;
    logic all;
    all = 1'b1;
    i_eep_master.start();
    i_eep_master.wr(dev, k);
    all &= k;
    i_eep_master.wr(a, k);
    all &= k;
    for (int i = 0; i < n; i++) begin
      i_eep_master.wr(a + i[7:0], k);
      all &= k;
      if (ok) mdl[{dev[1], a[7:4], a[3:0] + i[3:0]}] = a + i[7:0];
    end
    i_eep_master.stop();
    chk({7'h00, all}, 8'h01);
    repeat (3) @(negedge ref_clk);
    chk({7'h00, busy}, {7'h00, ok});
    if (ok) begin
      i_eep_master.start();
      i_eep_master.wr(dev, k);
      i_eep_master.stop();
      chk({7'h00, k}, 8'h00);
    end
    for (int i = 0; i < WC + 10 && busy !== 1'b0; i++) @(negedge ref_clk);
    chk({7'h00, standby}, 8'h01);
  endtask : wtx
  task automatic rtx(input logic [7:0] dev, input logic [7:0] a, input int n);
    logic k;
    logic [7:0] d;
    i_eep_master.start();
    i_eep_master.wr(dev, k);
    i_eep_master.wr(a, k);
    i_eep_master.start();
    i_eep_master.wr(dev | 8'h01, k);
    for (int i = 0; i < n; i++) begin
      i_eep_master.rd(i < n - 1, d);
      chk(d, mdl[{dev[1], a} + i[8:0]]);
    end
    i_eep_master.stop();
  endtask : rtx
  // ====
  // scenarios
  task automatic s_reset;
    chk({6'h00, busy, sda.oe}, 8'h00);
    chk({6'h00, standby, id_locked}, 8'h02);
  endtask : s_reset
  task automatic s_page;
    wtx(8'ha8, 8'h1d, 5, 1'b1);
    rtx(8'ha8, 8'h0e, 20);
    wtx(8'haa, 8'h05, 1, 1'b1);
    rtx(8'haa, 8'h04, 3);
  endtask : s_page
  task automatic s_sel;
    logic k;
    logic [7:0] bad [4] = '{8'ha0, 8'hac, 8'ha4, 8'h28};
    for (int i = 0; i < 4; i++) begin
      i_eep_master.start();
      i_eep_master.wr(bad[i], k);
      i_eep_master.stop();
      chk({7'h00, k}, 8'h00);
    end
  endtask : s_sel
  task automatic s_wp;
    wp = 1'b1;
    wtx(8'ha8, 8'h40, 2, 1'b0);
    wp_unlock = 1'b1;
    wtx(8'ha8, 8'h44, 2, 1'b1);
    rtx(8'ha8, 8'h40, 6);
    wp = 1'b0;
    wp_unlock = 1'b0;
  endtask : s_wp
  // id page slots mirror main model slots 0x003 and 0x006, which no other scenario reads
  task automatic s_id;
    wtx(8'hb8, 8'h03, 1, 1'b1);
    rtx(8'hb8, 8'h03, 1);
    id_lock_req = 1'b1;
    @(negedge ref_clk);
    id_lock_req = 1'b0;
    @(negedge ref_clk);
    chk({7'h00, id_locked}, 8'h01);
    wtx(8'hb8, 8'h06, 1, 1'b0);
    rtx(8'hb8, 8'h06, 1);
  endtask : s_id
  initial begin
    n_fail = 0;
    cmp_count = 0;
    rst = 1'b1;
    ce = 1'b1;
    wp = 1'b0;
    csh = 1'b1;
    csl = 1'b0;
    wp_unlock = 1'b0;
    id_lock_req = 1'b0;
    for (int i = 0; i < 512; i++) mdl[i] = 8'hff;
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    s_reset();
    s_page();
    s_sel();
    s_wp();
    s_id();
    complete_run();
  end
  // about 9500 cycles expected
  initial begin
    #6000000;
    n_fail++;
    complete_run();
  end
endmodule : eep_slave_tb

bind eep_slave eep_checker #(.WRITE_CYCLES(WRITE_CYCLES)) i_eep_checker (.ref_clk(ref_clk), .rst(rst),
  .ce(ce), .pins(pins), .wp_unlock(wp_unlock), .id_lock_req(id_lock_req), .sda(sda), .busy(busy),
  .standby(standby), .id_locked(id_locked));
